// ---- hdl/cmc_pkg.sv ----
// Shared constants and state type for the CAN operating mode controller.
package cmc_pkg;

    // System clock rate in MHz (8 ns period).
    localparam int CLK_FREQ_MHZ = 125;
    // Nominal bit time on the bus in ns (1 Mbit/s).
    localparam int BIT_TIME_NS = 1000;
    // Clock cycles per bit, rounded down, never below one.
    localparam int BIT_CYCLES_RAW = (BIT_TIME_NS * CLK_FREQ_MHZ) / 1000;
    localparam int BIT_CYCLES = (BIT_CYCLES_RAW < 1) ? 1 : BIT_CYCLES_RAW;
    // Consecutive recessive bits that mark an idle bus.
    localparam int IDLE_BITS = 11;
    // Geometry of the buffer in the received bit path.
    localparam int BUF_DEPTH = 2;
    localparam int BUF_WIDTH = 1;
    // Bus levels.
    localparam logic RECESSIVE = 1'b1;
    localparam logic DOMINANT = 1'b0;
    // Reset values of the acknowledge outputs.
    localparam logic INIT_ACK_RST = 1'b0;
    localparam logic LP_ACK_RST = 1'b1;

    // Operating mode states, one-hot.
    typedef enum logic [4:0] {
        ST_SLEEP = 5'h01,
        ST_WAKE_SYNC = 5'h02,
        ST_INIT = 5'h04,
        ST_SYNC = 5'h08,
        ST_NORMAL = 5'h10
    } cmc_state_e;

endpackage

// ---- hdl/cmc_bit_buf.sv ----
// Small FIFO that carries sampled bus bits to the protocol core.
`timescale 1ns/1ps
module cmc_bit_buf
    import cmc_pkg::*;
#(
    parameter int WIDTH = BUF_WIDTH,
    parameter int DEPTH = BUF_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Storage for the entries.
    logic [WIDTH-1:0] mem [DEPTH];
    // Write and read positions.
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    // Number of stored entries.
    logic [PW:0] count;
    logic push;
    logic pop;

    // Full and empty come straight from the count, so they are exact.
    assign in_ready_o = (count != DEPTH[PW:0]);
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Entries are written at the write pointer.
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    // Occupancy follows push and pop together.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end

endmodule

// ---- hdl/cmc_idle_det.sv ----
// Counter of consecutive recessive bits that reports an idle bus.
`timescale 1ns/1ps
module cmc_idle_det
    import cmc_pkg::*;
#(
    parameter int NBITS = IDLE_BITS
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic restart_i,
    input wire logic bit_valid_i,
    input wire logic bit_i,
    output logic idle_o
);

    localparam int CW = $clog2(NBITS + 1);

    // Recessive bits seen since the last dominant bit or restart.
    logic [CW-1:0] run;

    // A dominant bit or a restart begins the count again; the count
    // saturates so a long idle bus stays idle.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run <= '0;
        end else if (restart_i) begin
            run <= '0;
        end else if (bit_valid_i) begin
            if (bit_i == DOMINANT) begin
                run <= '0;
            end else if (run != NBITS[CW-1:0]) begin
                run <= run + 1'b1;
            end
        end
    end

    assign idle_o = (run == NBITS[CW-1:0]);

endmodule

// ---- hdl/cmc_mode_ctrl.sv ----
// Operating mode controller: init, normal, sleep and test routing.
`timescale 1ns/1ps
// Summary of operation
// - Reset leaves the controller in sleep.
// - Acknowledge bits set once mode entered.
// - Normal mode when neither acknowledge set; both are also clear in ST_SYNC, before the bus is idle.
// - Wait 11 recessive bits before bus use.
// - Init acknowledge clears only after leaving.
// - Init mode stops transfers, transmit recessive.
// - Init entry keeps configuration unchanged.
// - Sleep stops core clock, freezes status.
// - Init request during sleep not acknowledged.
// - Sleep left on software clear or activity.
// - Auto wake-up clears sleep request itself.
// - Wake-up event raised when enabled.
// - Sleep exit synchronises before clearing acknowledge.
// - Test bits taken only in init mode.
// - Silent mode never drives or starts transmission.
// - Silent dominant bits looped back internally.
// - Loop-back stores own frames as received.
// - Loop-back ignores acknowledge errors.
// - Loop-back feeds transmit to receive internally.
// - Combined mode disconnects receive, transmit recessive.
module cmc_mode_ctrl
    import cmc_pkg::*;
#(
    parameter int BIT_CLKS = BIT_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic init_request_i,
    input wire logic sleep_request_i,
    input wire logic auto_wakeup_enable_i,
    input wire logic wakeup_irq_enable_i,
    input wire logic silent_select_i,
    input wire logic loopback_select_i,
    input wire logic bus_receive_pin_i,
    input wire logic core_tx_i,
    input wire logic core_rx_ready_i,
    output logic init_acknowledge_o,
    output logic low_power_acknowledge_o,
    output logic sleep_request_clear_o,
    output logic wakeup_event_o,
    output logic bus_transmit_pin_o,
    output logic core_rx_o,
    output logic core_rx_bit_o,
    output logic core_rx_valid_o,
    output logic core_clk_run_o,
    output logic core_enable_o,
    output logic tx_start_allow_o,
    output logic ack_err_ignore_o,
    output logic loopback_store_o
);

    localparam int TW = (BIT_CLKS > 1) ? $clog2(BIT_CLKS) : 1;

    // Two-stage synchroniser for the receive pin.
    logic rx_meta;
    logic rx_sync;
    // Mode state and its next value.
    cmc_state_e state;
    cmc_state_e next_state;
    // Test mode selection, taken only while in initialisation.
    logic silent_mode;
    logic loop_mode;
    // Set after an automatic wake-up until software drops its request.
    logic wake_pending;
    // Bus activity already reported in this sleep period.
    logic act_seen;
    // Bit sampling timer and the routed receive level.
    logic [TW-1:0] bit_timer;
    logic bit_tick;
    logic rx_route;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_bit;
    logic bus_idle;
    logic sleep_eff;
    logic activity;
    logic auto_wake;
    logic sync_restart;

    // The pin is asynchronous, so only the second stage is read.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_meta <= RECESSIVE;
            rx_sync <= RECESSIVE;
        end else begin
            rx_meta <= bus_receive_pin_i;
            rx_sync <= rx_meta;
        end
    end

    // A sleep request counts only until an automatic wake-up has
    // consumed it; otherwise a slow software clear would send the
    // controller straight back to sleep.
    assign sleep_eff = sleep_request_i && !wake_pending;
    // Activity is any dominant level on the real pin while asleep.
    assign activity = (state == ST_SLEEP) && (rx_sync == DOMINANT);
    assign auto_wake = activity && auto_wakeup_enable_i;
    // Synchronisation counts afresh each time a sync state is entered.
    assign sync_restart = (next_state != state) &&
        ((next_state == ST_SYNC) || (next_state == ST_WAKE_SYNC));

    // Receive routing for the core.
    always_comb begin
        if (loop_mode) begin
            rx_route = core_tx_i;
        end else if (silent_mode) begin
            rx_route = rx_sync & core_tx_i;
        end else begin
            rx_route = rx_sync;
        end
    end

    // Mode transitions.
    always_comb begin
        next_state = state;
        case (state)
            ST_SLEEP: begin
                // Init requests are ignored here; sleep is left only by
                // a cleared request or by automatic wake-up.
                if (!sleep_eff || auto_wake) begin
                    next_state = ST_WAKE_SYNC;
                end
            end
            ST_WAKE_SYNC: begin
                if (sleep_eff) begin
                    next_state = ST_SLEEP;
                end else if (bus_idle) begin
                    next_state = init_request_i ? ST_INIT : ST_NORMAL;
                end
            end
            ST_INIT: begin
                if (!init_request_i) begin
                    next_state = sleep_eff ? ST_SLEEP : ST_SYNC;
                end
            end
            ST_SYNC, ST_NORMAL: begin
                // Init takes priority over sleep when both are asked.
                if (init_request_i) begin
                    next_state = ST_INIT;
                end else if (sleep_eff) begin
                    next_state = ST_SLEEP;
                end else if (state == ST_SYNC && bus_idle) begin
                    next_state = ST_NORMAL;
                end
            end
            default: begin
                next_state = ST_SLEEP;
            end
        endcase
    end

    // State register; reset lands in sleep.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_SLEEP;
        end else begin
            state <= next_state;
        end
    end

    // Acknowledges follow the state being entered, so software sees
    // them in the same cycle as the mode changes.  Sleep keeps its
    // acknowledge through the wake synchronisation.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            init_acknowledge_o <= INIT_ACK_RST;
            low_power_acknowledge_o <= LP_ACK_RST;
        end else begin
            init_acknowledge_o <= (next_state == ST_INIT);
            low_power_acknowledge_o <= (next_state == ST_SLEEP) ||
                (next_state == ST_WAKE_SYNC);
        end
    end

    // Test selections are sampled only in init, so a change made in
    // another mode has no effect until the next init.  Other
    // configuration is held outside and never touched here.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            silent_mode <= 1'b0;
            loop_mode <= 1'b0;
        end else if (state == ST_INIT) begin
            silent_mode <= silent_select_i;
            loop_mode <= loopback_select_i;
        end
    end

    // Wake-up bookkeeping and the automatic request clear.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wake_pending <= 1'b0;
            act_seen <= 1'b0;
            sleep_request_clear_o <= 1'b0;
            wakeup_event_o <= 1'b0;
        end else begin
            sleep_request_clear_o <= auto_wake;
            wakeup_event_o <= activity && !act_seen &&
                wakeup_irq_enable_i;
            // A new wake-up wins over the release by software.
            if (auto_wake) begin
                wake_pending <= 1'b1;
            end else if (!sleep_request_i) begin
                wake_pending <= 1'b0;
            end
            if (activity) begin
                act_seen <= 1'b1;
            end else if (state != ST_SLEEP) begin
                act_seen <= 1'b0;
            end
        end
    end

    // Bit timer; it stalls while the buffer is full, so no sample is
    // dropped, at the cost of stretching the idle count.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bit_timer <= '0;
        end else if (sync_restart) begin
            bit_timer <= '0;
        end else if (bit_tick) begin
            bit_timer <= '0;
        end else if (bit_timer != TW'(BIT_CLKS - 1)) begin
            bit_timer <= bit_timer + 1'b1;
        end
    end

    assign bit_tick = (bit_timer == TW'(BIT_CLKS - 1)) && buf_in_ready;

    // Bus routing and core controls, all registered.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_transmit_pin_o <= RECESSIVE;
            core_rx_o <= RECESSIVE;
            core_clk_run_o <= 1'b0;
            core_enable_o <= 1'b0;
            tx_start_allow_o <= 1'b0;
            ack_err_ignore_o <= 1'b0;
            loopback_store_o <= 1'b0;
        end else begin
            // Only normal mode without silent may drive dominant bits.
            if (next_state != ST_NORMAL || silent_mode) begin
                bus_transmit_pin_o <= RECESSIVE;
            end else begin
                bus_transmit_pin_o <= core_tx_i;
            end
            core_rx_o <= rx_route;
            core_clk_run_o <= (next_state != ST_SLEEP);
            core_enable_o <= (next_state == ST_NORMAL);
            tx_start_allow_o <= (next_state == ST_NORMAL) &&
                !silent_mode;
            ack_err_ignore_o <= loop_mode;
            loopback_store_o <= loop_mode;
        end
    end

    // Idle detection on the sampled routed level.
    cmc_idle_det #(
        .NBITS(IDLE_BITS)
    ) u_idle (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .restart_i(sync_restart),
        .bit_valid_i(bit_tick),
        .bit_i(rx_route),
        .idle_o(bus_idle)
    );

    // Sampled bits to the core; the core may stall it.
    cmc_bit_buf #(
        .WIDTH(BUF_WIDTH),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .in_data_i(rx_route),
        .in_valid_i(bit_tick),
        .in_ready_o(buf_in_ready),
        .out_data_o(buf_out_bit),
        .out_valid_o(buf_out_valid),
        .out_ready_i(core_rx_ready_i)
    );

    // The buffer output is registered once more for the top outputs.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            core_rx_bit_o <= RECESSIVE;
            core_rx_valid_o <= 1'b0;
        end else begin
            core_rx_bit_o <= buf_out_bit;
            core_rx_valid_o <= buf_out_valid;
        end
    end

    // Checks.
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    a_sleep_ack_state:
    assert property ((state == ST_SLEEP) |-> low_power_acknowledge_o)
        else $error("sleep state without low power acknowledge");
    a_init_ack_state:
    assert property ((state == ST_INIT) == init_acknowledge_o)
        else $error("init acknowledge does not match init state");
    a_normal_no_ack:
    assert property ((state == ST_NORMAL) |->
        (!init_acknowledge_o && !low_power_acknowledge_o && core_enable_o))
        else $error("normal mode with acknowledge or core off");
    a_sync_needs_idle:
    assert property ((state == ST_SYNC) && !bus_idle && !init_request_i
        && !sleep_eff |=> (state == ST_SYNC))
        else $error("normal entered before bus idle");
    a_init_tx_rec:
    assert property ((state == ST_INIT) |->
        (bus_transmit_pin_o == RECESSIVE) && !core_enable_o)
        else $error("transmit not recessive in init");
    a_sleep_no_init:
    assert property ((state == ST_SLEEP) && init_request_i |=>
        !init_acknowledge_o)
        else $error("init acknowledged while asleep");
    a_auto_wake_clr:
    assert property (auto_wake |=> sleep_request_clear_o ##1
        (state == ST_WAKE_SYNC || state == ST_SLEEP))
        else $error("automatic wake-up did not clear request");
    a_silent_tx:
    assert property (silent_mode && $past(silent_mode) |->
        (bus_transmit_pin_o == RECESSIVE) && !tx_start_allow_o)
        else $error("silent mode drove the bus");
    a_loop_rx:
    assert property (loop_mode |=> (core_rx_o == $past(core_tx_i)))
        else $error("loop-back receive not fed from transmit");
    a_clk_stop:
    assert property ((state == ST_SLEEP) |-> !core_clk_run_o)
        else $error("core clock runs in sleep");

endmodule

// ---- test/cmc_bus_model.sv ----
// Far-side model: other bus nodes plus the transceiver loop to the rx pin.
`timescale 1ns/1ps
module cmc_bus_model #(
    parameter int DELAY = 2
) (
    input wire logic sys_clk_i,
    input wire logic bus_transmit_pin_i,
    input wire logic node_dominant_i,
    output logic bus_receive_pin_o
);
    // Transceiver delay line; a larger DELAY gives a slow loop (min 2).
    logic [DELAY-1:0] dly = '1;

    // Wired-AND bus: any dominant driver wins, the pull-up leaves it high.
    always @(posedge sys_clk_i) begin
        dly <= {dly[DELAY-2:0], bus_transmit_pin_i & ~node_dominant_i};
    end

    // The pin shows the bus level after the loop delay.
    assign bus_receive_pin_o = dly[DELAY-1];
endmodule

// ---- test/tb_can_operating_mode_control.sv ----
// Self-checking bench for the operating mode controller.
`timescale 1ns/1ps
module tb_can_operating_mode_control;
    import cmc_pkg::*;
    // Short bit time keeps the idle waits brief.
    localparam int BC = 4;
    // Bounds on the bus sync wait, measured from the start of each wait.
    localparam int LB = (IDLE_BITS - 1) * BC + 2;
    localparam int UB = (IDLE_BITS + 3) * BC + 20;
    localparam int TMO = 6000;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic init_req = 1'b0;
    logic sleep_req = 1'b1;
    logic awu = 1'b1;
    logic wie = 1'b1;
    logic sil = 1'b0;
    logic lbk = 1'b0;
    logic core_tx = 1'b1;
    logic rdy = 1'b1;
    logic node_dom = 1'b0;
    logic rx_pin;
    logic init_ack, lp_ack, sreq_clr, wake_ev, tx_pin, core_rx;
    logic rx_bit, rx_valid, clk_run, core_en, tx_allow, ack_ign, lb_store;
    logic [2:0] obs;
    logic [1:0] exp_q[$];
    logic [31:0] seed = 32'h500FF195;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    // Mode seen by software: enable, init ack, low-power ack.
    assign obs = {core_en, init_ack, lp_ack};

    cmc_mode_ctrl #(.BIT_CLKS(BC)) dut (
        .sys_clk_i(clk), .rstn_i(rstn), .init_request_i(init_req),
        .sleep_request_i(sleep_req), .auto_wakeup_enable_i(awu),
        .wakeup_irq_enable_i(wie), .silent_select_i(sil),
        .loopback_select_i(lbk), .bus_receive_pin_i(rx_pin),
        .core_tx_i(core_tx), .core_rx_ready_i(rdy),
        .init_acknowledge_o(init_ack), .low_power_acknowledge_o(lp_ack),
        .sleep_request_clear_o(sreq_clr), .wakeup_event_o(wake_ev),
        .bus_transmit_pin_o(tx_pin), .core_rx_o(core_rx),
        .core_rx_bit_o(rx_bit), .core_rx_valid_o(rx_valid),
        .core_clk_run_o(clk_run), .core_enable_o(core_en),
        .tx_start_allow_o(tx_allow), .ack_err_ignore_o(ack_ign),
        .loopback_store_o(lb_store));

    cmc_bus_model #(.DELAY(2)) bus (
        .sys_clk_i(clk), .bus_transmit_pin_i(tx_pin),
        .node_dominant_i(node_dom), .bus_receive_pin_o(rx_pin));

    // 125 MHz clock.
    initial begin
        forever #4 clk = ~clk;
    end

    // Software side: the sleep bit is cleared when hardware asks for it.
    always @(negedge clk) begin
        if (sreq_clr === 1'b1) begin
            sleep_req <= 1'b0;
        end
    end

    // Hang guard: a run past the ceiling counts as a mismatch.
    always @(posedge clk) begin
        cycles++;
        if (cycles == TMO) begin
            n_errors++;
            $display("Error %0t: timeout", $time);
            print_verdict();
        end
    end

    // Pulse watcher: each wake pulse takes the oldest expected note.
    always @(negedge clk) begin
        if (rstn && (wake_ev === 1'b1 || sreq_clr === 1'b1)) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("Error %0t: unexpected wake pulse", $time);
            end else begin
                check_pulse({wake_ev, sreq_clr}, exp_q.pop_front());
            end
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction

    task automatic check(input string what, input logic got, input logic e);
        num_checks++;
        if (got !== e) begin
            n_errors++;
            $display("Error %0t: %s got %b exp %b", $time, what, got, e);
        end
    endtask

    task automatic check_mode(input logic [2:0] got, input logic [2:0] e);
        num_checks++;
        if (got !== e) begin
            n_errors++;
            $display("Error %0t: mode got %b exp %b", $time, got, e);
        end
    endtask

    task automatic check_pulse(input logic [1:0] got, input logic [1:0] e);
        num_checks++;
        if (got !== e) begin
            n_errors++;
            $display("Error %0t: pulses got %b exp %b", $time, got, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Waits, bounded, for a mode pattern, then compares it.
    task automatic wait_obs(input logic [2:0] want, input int lim,
                            output int took);
        took = 0;
        while (obs !== want && took < lim) begin
            @(negedge clk);
            took++;
        end
        check_mode(obs, want);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        int took;
        logic first, got_first, seen0;
        // Reset for 12 cycles; outputs checked in the middle of it.
        cyc(6);
        check_mode(obs, 3'b001);
        check("tx idle", tx_pin, RECESSIVE);
        check("clock run", clk_run, 1'b0);
        cyc(6);
        rstn = 1'b1;
        cyc(2);
        // An init request while asleep is never acknowledged.
        init_req = 1'b1;
        cyc(20);
        check_mode(obs, 3'b001);
        init_req = 1'b0;
        $display("test reset and asleep done");
        // Bus activity while asleep, for every auto-wake and irq setting.
        for (int i = 0; i < 4; i++) begin
            sleep_req = 1'b1;
            wait_obs(3'b001, 4, took);
            check("clock run", clk_run, 1'b0);
            awu = i[1];
            wie = i[0];
            if (i != 0) begin
                exp_q.push_back({i[0], i[1]});
            end
            node_dom = 1'b1;
            cyc(BC);
            node_dom = 1'b0;
            if (i < 2) begin
                // No auto wake: still asleep until software clears.
                cyc(UB);
                check_mode(obs, 3'b001);
                sleep_req = 1'b0;
            end
            wait_obs(3'b100, UB, took);
            check("wake sync", took >= LB, 1'b1);
            check("clock run", clk_run, 1'b1);
            $display("test wake %0d done", i);
        end
        check("queue", exp_q.size() == 0, 1'b1);
        // Init entry, exit, sync and test routing for every test mode.
        for (int m = 0; m < 4; m++) begin
            init_req = 1'b1;
            wait_obs(3'b010, 4, took);
            core_tx = DOMINANT;
            // Configuration moves only while init is acknowledged; no
            // filter bank is modelled, so every bank stays inactive.
            sil = m[0];
            lbk = m[1];
            cyc(4);
            check("tx in init", tx_pin, RECESSIVE);
            core_tx = RECESSIVE;
            init_req = 1'b0;
            wait_obs(3'b000, 4, took);
            if (m == 0) begin
                // A dominant burst mid-sync must restart the idle count.
                cyc(4 * BC);
                node_dom = 1'b1;
                cyc(2 * BC);
                node_dom = 1'b0;
            end
            wait_obs(3'b100, UB, took);
            check("bus sync", took >= LB, 1'b1);
            for (int k = 0; k < 8; k++) begin
                seed = xs(seed);
                core_tx = seed[0];
                node_dom = seed[1];
                cyc(6);
                check("tx pin", tx_pin, sil ? 1'b1 : core_tx);
                check("core rx", core_rx, lbk ? core_tx :
                      ((sil | core_tx) & ~node_dom &
                       (sil ? core_tx : 1'b1)));
            end
            check("tx allow", tx_allow, ~sil);
            check("ack ignore", ack_ign, lbk);
            check("store own", lb_store, lbk);
            // Test bits moved outside init are not taken.
            sil = ~sil;
            lbk = ~lbk;
            cyc(3);
            check("tx allow held", tx_allow, ~m[0]);
            check("ack ignore held", ack_ign, m[1]);
            sil = m[0];
            lbk = m[1];
            core_tx = RECESSIVE;
            node_dom = 1'b0;
            if (m == 0) begin
                // Let the random bits drain first, so that only
                // recessive samples are buffered when the core stalls.
                cyc(2 * BC);
                // Stall the core: the buffer fills and keeps its bits.
                rdy = 1'b0;
                cyc(12 * BC);
                check("buf valid", rx_valid, 1'b1);
                node_dom = 1'b1;
                cyc(6 * BC);
                check("buf held", rx_bit, RECESSIVE);
                rdy = 1'b1;
                got_first = 1'b0;
                seen0 = 1'b0;
                first = 1'b0;
                repeat (8 * BC) begin
                    @(negedge clk);
                    if (rx_valid === 1'b1 && !got_first) begin
                        first = rx_bit;
                        got_first = 1'b1;
                    end
                    if (rx_valid === 1'b1 && rx_bit === DOMINANT) begin
                        seen0 = 1'b1;
                    end
                end
                check("buf oldest", first, RECESSIVE);
                check("buf newer", seen0, 1'b1);
                node_dom = 1'b0;
            end
            $display("test mode %0d done", m);
        end
        print_verdict();
    end
endmodule
